// File: esfs_alu.v
`timescale 1ns/1ps
`include "esfs_consts.vh"

module esfs_alu
#(
	parameter DATA_WIDTH  = `ESFS_DATA_WIDTH,
	parameter FIELD_WIDTH = `ESFS_FIELD_WIDTH
)
(
	// clock and reset
	input  wire                     clk,
	input  wire                     resetn,
	// instruction issue
	input  wire                     issue,
	input  wire [`ESFS_OP_WIDTH-1:0] op_code,
	input  wire                     imm_sel,
	input  wire [FIELD_WIDTH-1:0]   dest_field,
	input  wire [FIELD_WIDTH-1:0]   src_field,
	input  wire [DATA_WIDTH-1:0]    dest_value,
	input  wire [DATA_WIDTH-1:0]    src_reg_value,
	input  wire                     update_null_flag_option,
	input  wire                     update_borrow_flag_option,
	input  wire                     suppress_writeback_option,
	// flag preload from the chain's leading step
	input  wire                     flag_load,
	input  wire                     flag_load_borrow,
	input  wire                     flag_load_null,
	// slot status
	output reg                      busy,
	output reg                      done,
	// writeback
	output reg                      wb_en,
	output reg  [FIELD_WIDTH-1:0]   wb_addr,
	output reg  [DATA_WIDTH-1:0]    wb_data,
	// flags
	output reg                      borrow_flag,
	output reg                      result_null_flag
);

	// ---------------------------------------------------------------
	// captured instruction
	// ---------------------------------------------------------------
	reg [`ESFS_OP_WIDTH-1:0] op_q;
	reg [DATA_WIDTH-1:0]     d_q;
	reg [DATA_WIDTH-1:0]     s_q;
	reg                      opt_null_q;
	reg                      opt_borrow_q;
	reg                      opt_nowb_q;
	reg [`ESFS_CNT_WIDTH-1:0] slot_cnt;

	wire take   = issue & ~busy;
	// compare at the counter's own width so no bits are dropped silently
	wire finish = busy & (slot_cnt == `ESFS_SLOT_LAST);

	// ---------------------------------------------------------------
	// arithmetic
	// ---------------------------------------------------------------
	// one extra bit keeps both the unsigned borrow and the signed overflow
	wire [DATA_WIDTH:0] d_u = {1'b0, d_q};
	wire [DATA_WIDTH:0] s_u = {1'b0, s_q};
	wire [DATA_WIDTH:0] d_s = {d_q[DATA_WIDTH-1], d_q};
	wire [DATA_WIDTH:0] s_s = {s_q[DATA_WIDTH-1], s_q};
	wire [DATA_WIDTH:0] c_x = {{DATA_WIDTH{1'b0}}, borrow_flag};

	// zero test shared by every null flag path
	function is_zero;
		input [DATA_WIDTH-1:0] value;
	begin
		is_zero = (value == {DATA_WIDTH{1'b0}});
	end
	endfunction

	// guard and sign bit disagree when the signed result wrapped
	function is_wrap;
		input [DATA_WIDTH:0] value;
	begin
		is_wrap = value[DATA_WIDTH] ^ value[DATA_WIDTH-1];
	end
	endfunction

	wire [DATA_WIDTH:0] diff_u = d_u - s_u - c_x;
	wire [DATA_WIDTH:0] diff_s = d_s - s_s - c_x;
	wire [DATA_WIDTH:0] sum_s = borrow_flag ? (d_s - s_s) : (d_s + s_s);

	reg [DATA_WIDTH-1:0] next_result;
	reg                  next_borrow;
	reg                  next_null;
	reg                  op_valid;

	// result and flag candidates per operation
	always @*
	begin
		next_result = diff_u[DATA_WIDTH-1:0];
		next_borrow = borrow_flag;
		next_null   = result_null_flag;
		op_valid    = 1'b1;
		case (op_q)
			`ESFS_OP_CHAIN_DIFF:
			begin
				next_result = diff_u[DATA_WIDTH-1:0];
				next_borrow = diff_u[DATA_WIDTH];
				next_null   = result_null_flag & is_zero(diff_u[DATA_WIDTH-1:0]);
			end
			`ESFS_OP_CHAIN_SDIFF:
			begin
				next_result = diff_s[DATA_WIDTH-1:0];
				next_borrow = is_wrap(diff_s);
				next_null   = result_null_flag & is_zero(diff_s[DATA_WIDTH-1:0]);
			end
			`ESFS_OP_STEER_SUM:
			begin
				next_result = sum_s[DATA_WIDTH-1:0];
				// overflow and zero of the sum
				next_borrow = is_wrap(sum_s);
				next_null   = is_zero(sum_s[DATA_WIDTH-1:0]);
			end
			default:
			begin
				// unknown code: slot still runs, no write enable or flag update, but wb_data still takes the difference
				op_valid    = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// slot sequencing and capture
	// ---------------------------------------------------------------
	// fixed slot: take, two wait edges, commit
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy         <= 1'b0;
			slot_cnt     <= {`ESFS_CNT_WIDTH{1'b0}};
			op_q         <= {`ESFS_OP_WIDTH{1'b0}};
			d_q          <= {DATA_WIDTH{1'b0}};
			s_q          <= {DATA_WIDTH{1'b0}};
			opt_null_q   <= 1'b0;
			opt_borrow_q <= 1'b0;
			opt_nowb_q   <= 1'b0;
			wb_addr      <= {FIELD_WIDTH{1'b0}};
		end
		else if (take)
		begin
			busy         <= 1'b1;
			slot_cnt     <= {`ESFS_CNT_WIDTH{1'b0}};
			op_q         <= op_code;
			d_q          <= dest_value;
			s_q          <= imm_sel ? {{(DATA_WIDTH-FIELD_WIDTH){1'b0}}, src_field} : src_reg_value;
			opt_null_q   <= update_null_flag_option;
			opt_borrow_q <= update_borrow_flag_option;
			opt_nowb_q   <= suppress_writeback_option;
			wb_addr      <= dest_field;
		end
		else if (finish)
		begin
			busy     <= 1'b0;
			slot_cnt <= {`ESFS_CNT_WIDTH{1'b0}};
		end
		else if (busy)
		begin
			slot_cnt <= slot_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// commit: writeback and flags
	// ---------------------------------------------------------------
	// a preload in the commit cycle loses only to a flag the step updates, so a chain step is never undone
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			done             <= 1'b0;
			wb_en            <= 1'b0;
			wb_data          <= {DATA_WIDTH{1'b0}};
			borrow_flag      <= `ESFS_FLAG_RESET;
			result_null_flag <= `ESFS_FLAG_RESET;
		end
		else
		begin
			done  <= finish;
			wb_en <= finish & op_valid & ~opt_nowb_q;
			if (finish)
			begin
				wb_data <= next_result;
			end
			if (finish & op_valid)
			begin
				if (opt_borrow_q)
				begin
					borrow_flag <= next_borrow;
				end
				else if (flag_load)
				begin
					borrow_flag <= flag_load_borrow;
				end
				if (opt_null_q)
				begin
					result_null_flag <= next_null;
				end
				else if (flag_load)
				begin
					result_null_flag <= flag_load_null;
				end
			end
			else if (flag_load)
			begin
				borrow_flag      <= flag_load_borrow;
				result_null_flag <= flag_load_null;
			end
		end
	end

endmodule // esfs_alu

// File: esfs_alu_properties.sv
`timescale 1ns/1ps
// ----
// slot, writeback and flag checks
// ----
module esfs_alu_checker (
	// control, status, writeback and flag ports watched; operand values are not
	input wire        clk,
	input wire        resetn,
	input wire        issue,
	input wire [5:0]  op_code,
	input wire [8:0]  dest_field,
	input wire        update_null_flag_option,
	input wire        suppress_writeback_option,
	input wire        flag_load,
	input wire        busy,
	input wire        done,
	input wire        wb_en,
	input wire [8:0]  wb_addr,
	input wire [31:0] wb_data,
	input wire        borrow_flag,
	input wire        result_null_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_slot_busy: assert property (issue && !busy |=> busy[*3] ##1 !busy)
		else $error("slot length wrong");
	a_done_time: assert property (issue && !busy |-> ##4 done ##1 !done)
		else $error("done pulse misplaced");
	a_done_cause: assert property (done |-> $past(busy) && !busy)
		else $error("done without slot");
	a_wb_suppress: assert property (issue && !busy && suppress_writeback_option |-> ##4 !wb_en)
		else $error("suppressed write seen");
	a_wb_done: assert property (wb_en |-> done)
		else $error("write outside commit");
	a_addr_echo: assert property (issue && !busy |=> wb_addr == $past(dest_field))
		else $error("write address wrong");
	a_flag_cause: assert property ($changed(borrow_flag) || $changed(result_null_flag) |-> done || $past(flag_load))
		else $error("flag changed unasked");
	a_data_commit: assert property ($changed(wb_data) |-> done)
		else $error("result changed off commit");
	// a cleared null flag stays cleared through a chained step
	// a preload in the take cycle is legal and may seed the flag, so it is left out
	a_null_sticky: assert property ((issue && !busy && !flag_load && op_code[4]
		&& update_null_flag_option && !result_null_flag)
		##1 !flag_load[*3] |=> !result_null_flag)
		else $error("null flag set from clear");
endmodule // esfs_alu_checker

bind esfs_alu esfs_alu_checker esfs_alu_checker_inst (.clk, .resetn, .issue, .op_code, .dest_field,
	.update_null_flag_option, .suppress_writeback_option, .flag_load, .busy, .done, .wb_en, .wb_addr,
	.wb_data, .borrow_flag, .result_null_flag);

// File: esfs_alu_tb.sv
`timescale 1ns/1ps
`include "esfs_consts.vh"
// ----
// bench
// ----
module esfs_alu_tb;
	localparam OD = `ESFS_OP_CHAIN_DIFF;
	localparam OS = `ESFS_OP_CHAIN_SDIFF;
	localparam OM = `ESFS_OP_STEER_SUM;
	reg         clk = 0, resetn = 0, issue = 0, im = 0, uz = 0, uc = 0, nr = 0, ld = 0, lb = 0, lz = 0;
	reg  [5:0]  op = 0;
	reg  [8:0]  df = 0, sf = 0;
	reg  [31:0] dv = 0, sv = 0, r;
	wire        busy, done, wb_en, bf, nf;
	wire [8:0]  wb_addr;
	wire [31:0] wb_data;
	integer     error_cnt = 0, comparisons = 0, i;
	reg         mb = 0, mz = 0, hold = 0;
	reg  [43:0] q[$], e;
	// free-running clock
	always #50 clk = ~clk;
	esfs_alu esfs_alu_inst (.clk(clk), .resetn(resetn), .issue(issue), .op_code(op), .imm_sel(im),
		.dest_field(df), .src_field(sf), .dest_value(dv), .src_reg_value(sv), .update_null_flag_option(uz),
		.update_borrow_flag_option(uc), .suppress_writeback_option(nr), .flag_load(ld), .flag_load_borrow(lb),
		.flag_load_null(lz), .busy(busy), .done(done), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data),
		.borrow_flag(bf), .result_null_flag(nf));
	task chk(input [31:0] s, x);
	begin
		comparisons = comparisons + 1;
		if (s !== x) begin error_cnt = error_cnt + 1; $display("BAD t=%0t seen=%h exp=%h", $time, s, x); end
	end
	endtask
	task give_verdict;
	begin
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end
	endtask
	// bounded wait for outstanding commits; a note left over is a mismatch
	task drain;
		integer k;
	begin
		for (k = 0; k < 8 && q.size() != 0; k = k + 1) @(posedge clk);
		chk(q.size(), 32'h0000_0000);
	end
	endtask
	// seed both flags as a leading step would
	task fl(input b, z);
	begin
		@(posedge clk); ld <= 1; lb <= b; lz <= z;
		@(posedge clk); ld <= 0; mb = b; mz = z;
	end
	endtask
	// one slot: expectation noted first, then issued, next slot starts four edges on
	task run(input [5:0] o, input i1, input [31:0] d, s, input u1, u2, u3);
		reg [31:0] v;
		reg [32:0] t;
		reg        ov, en;
	begin
		v = i1 ? {23'h0, s[8:0]} : s;
		t = {d[31], d} - {v[31], v} - mb;
		if (o == OM) t = mb ? {d[31], d} - {v[31], v} : {d[31], d} + {v[31], v};
		ov = o == OD ? {1'b0, d} < {1'b0, v} + mb : t[32] ^ t[31];
		en = o == OD || o == OS || o == OM;
		if (en && u1) mz = (o == OM || mz) && t[31:0] == 0;
		if (en && u2) mb = ov;
		q.push_back({en && !u3, mb, mz, ~d[8:0], t[31:0]});
		@(posedge clk);
		issue <= 1'b1;
		op    <= o;
		im    <= i1;
		dv    <= d;
		sv    <= s;
		sf    <= s[8:0];
		df    <= ~d[8:0];
		uz    <= u1;
		uc    <= u2;
		nr    <= u3;
		// a held issue meets busy and must leave no trace; operand moves after take
		@(posedge clk);
		issue <= hold;
		dv    <= ~d;
		@(posedge clk);
		issue <= 1'b0;
		@(posedge clk);
	end
	endtask
	// watcher: oldest note against each commit
	always @(posedge clk) if (done === 1'b1)
	begin
		if (q.size() == 0)
		begin
			// commit with no slot pending
			chk(done, 1'b0);
		end
		else
		begin
			e = q.pop_front();
			chk({wb_en, bf, nf, wb_addr}, e[43:32]);
			if (e[43]) chk(wb_data, e[31:0]);
			chk(busy, 1'b0);
		end
	end
	initial
	begin
		i = $urandom(32'h5eed);
		repeat (12) @(posedge clk);
		resetn <= 1;
		fl(0, 1); run(OD, 0, 1, 1, 1, 1, 0);
		fl(1, 1); run(OD, 0, 1, 1, 1, 1, 0);
		fl(1, 0); run(OS, 0, 32'h8000_0001, 1, 1, 1, 0);
		fl(0, 1); run(OS, 0, 32'h7fff_ffff, 32'hffff_ffff, 1, 1, 0);
		fl(1, 1); run(OM, 0, 32'h8000_0000, 1, 1, 1, 0);
		fl(0, 1); run(OM, 1, 1, 32'hffff_ffff, 1, 1, 0);
		fl(0, 0); run(OM, 0, 32'h7fff_ffff, 1, 1, 1, 1);
		// chain back to back: borrow then signed top word
		fl(0, 1); run(OD, 0, 0, 1, 1, 1, 0); run(OS, 0, 0, 0, 1, 1, 0);
		$display("directed tests done");
		for (i = 0; i < 60; i = i + 1)
		begin
			r    = $urandom;
			hold = r[9];
			if (r[2]) fl(r[3], r[4]);
			run(r[1:0] == 0 ? OD : r[1:0] == 1 ? OS : r[1:0] == 2 ? OM : 6'h00,
				r[5], $urandom, $urandom, r[6], r[7], r[8]);
		end
		hold = 1'b0;
		$display("random tests done");
		drain;
		// reset in mid-run: flags seeded high must clear, outputs fall to zero
		fl(1, 1);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({busy, done, wb_en, bf, nf, wb_addr}, 14'h0000);
		chk(wb_data, 32'h0000_0000);
		resetn <= 1'b1;
		mb = 1'b0;
		mz = 1'b0;
		// first steps after release see the cleared flags
		run(OD, 0, 5, 3, 1, 1, 0);
		run(OD, 0, 3, 3, 1, 1, 0);
		$display("reset test done");
		drain;
		give_verdict;
	end
endmodule // esfs_alu_tb

// File: esfs_consts.vh
`ifndef ESFS_CONSTS_VH
`define ESFS_CONSTS_VH

// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define ESFS_OP_WIDTH        6
`define ESFS_OP_CHAIN_DIFF   6'h33
`define ESFS_OP_CHAIN_SDIFF  6'h37
`define ESFS_OP_STEER_SUM    6'h24

// ---------------------------------------------------------------
// field widths and timing
// ---------------------------------------------------------------
`define ESFS_DATA_WIDTH      32
`define ESFS_FIELD_WIDTH     9
`define ESFS_SLOT_CYCLES     4
`define ESFS_CNT_WIDTH       2
`define ESFS_SLOT_LAST       2'h2 // counter value of the commit cycle, slot cycles minus two
`define ESFS_FLAG_RESET      1'h0

`endif
